// ===== verification/gpdp_phy_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Link partner: free-running link clocks and receive frames
// ----------------------------------------------------------------
module gpdp_phy_model (
    output logic       o_tx_clk,
    output logic       o_rx_clk,
    output logic       o_dv,
    output logic       o_er,
    output logic [7:0] o_d
);
    // Slowed from the line rate so the sampling flops see every edge; offsets keep edges off the bench clock.
    initial begin
        o_tx_clk = 1'b0;
        #3;
        forever #80 o_tx_clk = ~o_tx_clk;
    end
    initial begin
        o_rx_clk = 1'b0;
        #37;
        forever #80 o_rx_clk = ~o_rx_clk;
    end
    initial begin
        o_dv = 1'b0;
        o_er = 1'b0;
        o_d  = 8'h00;
    end
    // Data changes on the falling edge so it is settled at the rising edge where it is taken.
    task automatic send(input logic [7:0] b, input logic e);
        @(negedge o_rx_clk);
        o_dv = 1'b1;
        o_er = e;
        o_d  = b;
    endtask
    task automatic idle();
        @(negedge o_rx_clk);
        o_dv = 1'b0;
        o_er = 1'b0;
        o_d  = ~o_d;
    endtask
endmodule

// ===== verification/gpdp_props.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port-level checks on the transmit and management paths
// ----------------------------------------------------------------
module gpdp_props (
    input wire logic                  i_clk,
    input wire logic                  i_rst,
    input wire gpdp_pkg::gpdp_opt_t   i_option,
    input wire gpdp_pkg::gpdp_speed_t i_speed,
    input wire logic                  i_tx_valid,
    input wire logic [7:0]            i_tx_byte,
    input wire logic                  i_tx_code_err,
    input wire logic                  o_tx_ready,
    input wire logic [7:0]            o_txd_pos,
    input wire logic [3:0]            o_txd_neg,
    input wire logic [7:0]            o_txd,
    input wire logic                  o_txen,
    input wire logic                  o_txer,
    input wire logic                  i_md_start,
    input wire logic [15:0]           i_md_word,
    input wire logic                  i_mdc_tick,
    input wire logic                  o_md_busy,
    input wire logic                  o_mdo,
    input wire logic                  o_mdio_en
);
    logic tk;
    logic te;
    logic cls;
    logic c10;
    assign tk  = o_tx_ready && i_tx_valid;
    assign te  = tk && i_tx_code_err;
    assign cls = i_option == gpdp_pkg::GPDP_CLASSIC;
    assign c10 = cls && i_speed == gpdp_pkg::GPDP_SPEED_10_100;
    // Counts bit ticks while the output enable stands, to bound the drive window.
    logic [4:0] en_ticks_reg;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            en_ticks_reg <= 5'h00;
        end else if (!o_mdio_en) begin
            en_ticks_reg <= 5'h00;
        end else if (i_mdc_tick) begin
            en_ticks_reg <= en_ticks_reg + 5'h01;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_txen_on: assert property (tk |=> o_txen) else $error("txen missing");
    a_txen_off: assert property (o_tx_ready && !i_tx_valid |=> !o_txen) else $error("txen stuck");
    a_txer_set: assert property (te |=> o_txer) else $error("txer missing");
    a_txer_en: assert property (o_txer |-> o_txen) else $error("txer outside frame");
    a_lo_equal: assert property (cls && !c10 |-> o_txd_neg == o_txd_pos[3:0]) else $error("nibbles differ");
    a_hi_unused: assert property (c10 |-> o_txd_pos[7:4] == 4'h0) else $error("high nibble used");
    a_nib_split: assert property (c10 && tk |=> {o_txd_neg, o_txd_pos[3:0]} == $past(i_tx_byte))
        else $error("nibble split wrong");
    a_gig_byte: assert property (!cls && tk |=> o_txd == $past(i_tx_byte)) else $error("txd wrong");
    a_md_first: assert property (i_md_start && !o_md_busy |=> o_mdio_en && o_mdo == $past(i_md_word[15]))
        else $error("mdo first bit wrong");
    a_md_en_span: assert property ($fell(o_mdio_en) |-> en_ticks_reg == 5'h10) else $error("mdio_en span wrong");
endmodule

bind gpdp_top gpdp_props gpdp_props_i (.i_clk, .i_rst, .i_option, .i_speed, .i_tx_valid, .i_tx_byte,
    .i_tx_code_err, .o_tx_ready, .o_txd_pos, .o_txd_neg, .o_txd, .o_txen, .o_txer, .i_md_start,
    .i_md_word, .i_mdc_tick, .o_md_busy, .o_mdo, .o_mdio_en);

// ===== verification/test_gpdp_top.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module test_gpdp_top;
    logic                  i_clk, i_rst, i_tx_valid, i_tx_code_err, i_md_start, i_md_read, i_mdc_tick, i_mdi;
    logic                  tclk, rclk, dv, er, cls, o_tx_ready, o_txen, o_txer, o_rx_valid, o_rx_err;
    logic                  o_md_busy, o_mdo, o_mdio_en;
    logic [7:0]            i_tx_byte, d, o_txd_pos, o_txd, o_rx_byte;
    logic [3:0]            o_txd_neg;
    logic [15:0]           i_md_word, md_got, o_md_rdata;
    logic [8:0]            rx_q[$];
    gpdp_pkg::gpdp_opt_t   opt;
    gpdp_pkg::gpdp_speed_t spd;
    int                    err_total, n_compared, md_n, tick_c;

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // The unused option's pins carry live junk so that listening to them shows up as extra bytes.
    assign cls = opt == gpdp_pkg::GPDP_CLASSIC;
    // Shared management line with a pull-up; the far side leaves it released.
    assign i_mdi = o_mdio_en ? o_mdo : 1'b1;
    gpdp_top gpdp_top_i (.i_clk, .i_rst, .i_option(opt), .i_speed(spd), .i_tx_mac_clk(tclk), .i_rx_mac_clk(rclk),
        .i_tx_valid, .i_tx_byte, .i_tx_code_err, .o_tx_ready, .o_txd_pos, .o_txd_neg, .o_txd, .o_txen, .o_txer,
        .i_rxdv_pos(cls ? dv : 1'b1), .i_rxdv_neg(1'b0), .i_rxer_pos(cls ? er : 1'b1), .i_rxer_neg(1'b0),
        .i_rxd_pos(cls ? d : ~d), .i_rxd_neg(~d[3:0]), .i_rxdv(cls ? 1'b1 : dv), .i_rxer(cls ? 1'b1 : er),
        .i_rxd(cls ? ~d : d), .o_rx_valid, .o_rx_err, .o_rx_byte, .i_md_start, .i_md_word, .i_md_read,
        .o_md_busy, .o_md_rdata, .i_mdc_tick, .i_mdi, .o_mdo, .o_mdio_en);
    gpdp_phy_model gpdp_phy_model_i (.o_tx_clk(tclk), .o_rx_clk(rclk), .o_dv(dv), .o_er(er), .o_d(d));

    always @(posedge i_clk) begin
        #1;
        tick_c++;
        i_mdc_tick = tick_c[2:0] == 3'h7;
    end
    always @(negedge i_clk) begin
        if (o_rx_valid === 1'b1) rx_q.push_back({o_rx_err, o_rx_byte});
        if (i_mdc_tick && o_mdio_en === 1'b1) begin
            md_got = {md_got[14:0], o_mdo};
            md_n++;
        end
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic set_mode(input gpdp_pkg::gpdp_opt_t o, input gpdp_pkg::gpdp_speed_t s);
        @(posedge i_clk);
        #1;
        i_rst = 1'b1;
        opt = o;
        spd = s;
        repeat (2) @(posedge i_clk);
        #1 i_rst = 1'b0;
    endtask
    task automatic tx_send(input logic [7:0] b, input logic e);
        int k;
        @(posedge i_clk);
        #1;
        i_tx_valid = 1'b1;
        i_tx_byte = b;
        i_tx_code_err = e;
        for (k = 0; k < 40 && o_tx_ready !== 1'b1; k++) @(negedge i_clk);
        chk("tx_ready", 16'h0001, {15'h0000, o_tx_ready});
        @(posedge i_clk);
        #1;
        i_tx_valid = 1'b0;
        i_tx_code_err = 1'b0;
        i_tx_byte = ~b;
        @(negedge i_clk);
        if (!cls) chk("txd", b, o_txd);
        else if (spd == gpdp_pkg::GPDP_SPEED_1G) chk("txd_pos_neg", {b, b[3:0]}, {o_txd_pos, o_txd_neg});
        else chk("txd_nibbles", {4'h0, b}, {o_txd_pos[7:4], o_txd_neg, o_txd_pos[3:0]});
        chk("txen_txer", {1'b1, e}, {o_txen, o_txer});
    endtask
    task automatic test_tx(input gpdp_pkg::gpdp_opt_t o, input gpdp_pkg::gpdp_speed_t s);
        set_mode(o, s);
        tx_send(8'hA5, 1'b0);
        tx_send(8'h3C, 1'b1);
        tx_send(8'h0F, 1'b0);
        $display("test_tx done");
    endtask
    task automatic test_rx(input gpdp_pkg::gpdp_opt_t o);
        logic [8:0] ex [3];
        ex = '{9'h05A, 9'h1C3, 9'h081};
        set_mode(o, gpdp_pkg::GPDP_SPEED_1G);
        rx_q.delete();
        gpdp_phy_model_i.send(8'h5A, 1'b0);
        gpdp_phy_model_i.send(8'hC3, 1'b1);
        gpdp_phy_model_i.idle();
        gpdp_phy_model_i.idle();
        gpdp_phy_model_i.send(8'h81, 1'b0);
        gpdp_phy_model_i.idle();
        gpdp_phy_model_i.idle();
        chk("rx_count", 16'h0003, 16'(rx_q.size()));
        for (int i = 0; i < 3; i++) chk("rx_byte", ex[i], rx_q[i]);
        $display("test_rx done");
    endtask
    task automatic test_md();
        int k;
        set_mode(gpdp_pkg::GPDP_GIGABIT, gpdp_pkg::GPDP_SPEED_1G);
        md_n = 0;
        md_got = 16'h0000;
        i_md_word = 16'hB2C4;
        i_md_read = 1'b1;
        i_md_start = 1'b1;
        @(posedge i_clk);
        #1 i_md_start = 1'b0;
        i_md_word = 16'h1111;
        repeat (8) @(posedge i_clk);
        #1 i_md_start = 1'b1;
        @(posedge i_clk);
        #1 i_md_start = 1'b0;
        for (k = 0; k < 400 && o_md_busy !== 1'b0; k++) @(negedge i_clk);
        chk("md_idle", 16'h0000, {15'h0000, o_md_busy});
        chk("md_bits", 16'hB2C4, md_got);
        chk("md_en_ticks", 16'h0010, 16'(md_n));
        chk("md_rdata", 16'hFFFF, o_md_rdata);
        $display("test_md done");
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        {i_rst, i_tx_valid, i_tx_code_err, i_md_start, i_md_read, i_mdc_tick} = 6'h20;
        {i_tx_byte, i_md_word, tick_c, err_total, n_compared, md_n} = '0;
        opt = gpdp_pkg::GPDP_CLASSIC;
        spd = gpdp_pkg::GPDP_SPEED_10_100;
        test_tx(gpdp_pkg::GPDP_CLASSIC, gpdp_pkg::GPDP_SPEED_10_100);
        test_tx(gpdp_pkg::GPDP_CLASSIC, gpdp_pkg::GPDP_SPEED_1G);
        test_tx(gpdp_pkg::GPDP_SERIAL, gpdp_pkg::GPDP_SPEED_1G);
        test_rx(gpdp_pkg::GPDP_CLASSIC);
        test_rx(gpdp_pkg::GPDP_SERIAL);
        test_rx(gpdp_pkg::GPDP_GIGABIT);
        test_md();
        tally_and_finish();
    end
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
endmodule

// ===== verilog/gpdp_defs.svh
`ifndef GPDP_DEFS_SVH
`define GPDP_DEFS_SVH

// Option codes.
`define GPDP_OPT_CLASSIC   2'h0
`define GPDP_OPT_SERIAL    2'h1
`define GPDP_OPT_GIGABIT   2'h2

// Transmit MAC clock rates in kHz.
`define GPDP_TXCLK_1G_KHZ   125000
`define GPDP_TXCLK_100_KHZ  12500
`define GPDP_TXCLK_10_KHZ   1250

// System clock in kHz.
`define GPDP_SYSCLK_KHZ     100000

// Nibble field positions.
`define GPDP_HI_MSB 7
`define GPDP_HI_LSB 4
`define GPDP_LO_MSB 3
`define GPDP_LO_LSB 0

`endif

// ===== verilog/gpdp_pkg.sv
package gpdp_pkg;

    typedef enum logic [1:0] {
        GPDP_CLASSIC,
        GPDP_SERIAL,
        GPDP_GIGABIT
    } gpdp_opt_t;

    typedef enum logic {
        GPDP_SPEED_10_100,
        GPDP_SPEED_1G
    } gpdp_speed_t;

    typedef enum logic [1:0] {
        GPDP_MD_IDLE,
        GPDP_MD_DRIVE,
        GPDP_MD_LISTEN
    } gpdp_md_state_t;

endpackage

// ===== verilog/gpdp_rx_capture.sv
`timescale 1ns/1ps

module gpdp_rx_capture (
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    input  wire gpdp_pkg::gpdp_opt_t i_option,
    input  wire logic               i_mac_clk_rise,
    input  wire logic               i_mac_clk_fall,
    input  wire logic               i_dv_pos,
    input  wire logic               i_dv_neg,
    input  wire logic               i_er_pos,
    input  wire logic               i_er_neg,
    input  wire logic [7:0]         i_d_pos,
    input  wire logic [3:0]         i_d_neg,
    input  wire logic               i_dv,
    input  wire logic               i_er,
    input  wire logic [7:0]         i_d,
    gpdp_rx_if.src                  rx
);
    logic       neg_dv_reg;
    logic       neg_er_reg;
    logic [3:0] neg_d_reg;

    // -----------------------------------------------------------------
    // Falling-edge half of the classic path
    // -----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            neg_dv_reg <= 1'h0;
            neg_er_reg <= 1'h0;
            neg_d_reg  <= 4'h0;
        end else if (i_mac_clk_fall) begin
            neg_dv_reg <= i_dv_neg;
            neg_er_reg <= i_er_neg;
            neg_d_reg  <= i_d_neg;
        end
    end

    // -----------------------------------------------------------------
    // Byte assembly on the receive clock rising edge
    // -----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx.dv     <= 1'h0;
            rx.er     <= 1'h0;
            rx.data   <= 8'h00;
            rx.strobe <= 1'h0;
        end else begin
            rx.strobe <= i_mac_clk_rise;
            if (i_mac_clk_rise) begin
                if (i_option == gpdp_pkg::GPDP_CLASSIC) begin
                    rx.dv   <= i_dv_pos | neg_dv_reg;                           // [RULE13]
                    rx.er   <= i_er_pos | neg_er_reg;
                    rx.data <= i_dv_pos ? i_d_pos : {neg_d_reg, i_d_pos[3:0]};
                end else begin
                    rx.dv   <= i_dv;                                            // [RULE14]
                    rx.er   <= i_er;
                    rx.data <= i_d;
                end
            end
        end
    end
endmodule

// ===== verilog/gpdp_rx_if.sv
`timescale 1ns/1ps

interface gpdp_rx_if;
    logic       dv;
    logic       er;
    logic [7:0] data;
    logic       strobe;

    modport src (output dv, output er, output data, output strobe);
    modport dst (input dv, input er, input data, input strobe);
endinterface

// ===== verilog/gpdp_sync.sv
`timescale 1ns/1ps

module gpdp_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync,
    output logic      [W-1:0] o_rise
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // A change counts only once the second and third stages agree.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            o_sync <= '0;
            o_rise <= '0;
        end else begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int b = 0; b < W; b++) begin
                if (s2_reg[b] == s3_reg[b]) begin
                    o_sync[b] <= s3_reg[b];
                end
                o_rise[b] <= (s2_reg[b] == s3_reg[b]) && s3_reg[b] && !o_sync[b];
            end
        end
    end
endmodule

// ===== verilog/gpdp_top.sv
`timescale 1ns/1ps
`include "gpdp_defs.svh"

// Summary of operation
// [RULE1] Management output enable is high exactly while management data output is valid.
// [RULE2] Outside logic may merge management in, out and enable into one tristate line.
// [RULE3] In classic 1G, upper rising-edge bits become TXD[7:4] after outside flops.
// [RULE4] In 10/100 the upper rising-edge transmit bits are unused.
// [RULE5] Outside DDR cells mux the rising and falling low nibbles into TXD[3:0].
// [RULE6] In 1G the rising and falling low nibbles always carry equal values.
// [RULE7] In 10/100 the rising low nibble carries each byte's low nibble.
// [RULE8] In 10/100 the falling nibble carries the same byte's high nibble.
// [RULE9] Transmit clock is 125 MHz at 1G, 12.5 or 1.25 MHz otherwise.
// [RULE10] Serial-gigabit and gigabit options send one 8-bit TXD bus.
// [RULE11] Transmit enable is high exactly while the bus carries a frame byte.
// [RULE12] Transmit error marks a deliberately sent coding error on the current byte.
// [RULE13] Split receive-valid inputs are used only in the classic option.
// [RULE14] Other options take framing from single valid, 8-bit data and error inputs.
// [RULE15] Outside logic captures rising inputs on rising and falling on falling edge.
// [RULE16] Receive inputs pass an outside register stage on the receive clock.
// [RULE17] Receive data is meaningful only while receive valid is high.
// [RULE18] The PHY flags receive error on any error detected during a frame.
// [RULE19] Management data goes out on data output and comes back on data input.

module gpdp_top (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire gpdp_pkg::gpdp_opt_t i_option,
    input  wire gpdp_pkg::gpdp_speed_t i_speed,
    input  wire logic                i_tx_mac_clk,
    input  wire logic                i_rx_mac_clk,
    input  wire logic                i_tx_valid,
    input  wire logic [7:0]          i_tx_byte,
    input  wire logic                i_tx_code_err,
    output logic                     o_tx_ready,
    output logic [7:0]               o_txd_pos,
    output logic [3:0]               o_txd_neg,
    output logic [7:0]               o_txd,
    output logic                     o_txen,
    output logic                     o_txer,
    input  wire logic                i_rxdv_pos,
    input  wire logic                i_rxdv_neg,
    input  wire logic                i_rxer_pos,
    input  wire logic                i_rxer_neg,
    input  wire logic [7:0]          i_rxd_pos,
    input  wire logic [3:0]          i_rxd_neg,
    input  wire logic                i_rxdv,
    input  wire logic                i_rxer,
    input  wire logic [7:0]          i_rxd,
    output logic                     o_rx_valid,
    output logic                     o_rx_err,
    output logic [7:0]               o_rx_byte,
    input  wire logic                i_md_start,
    input  wire logic [15:0]         i_md_word,
    input  wire logic                i_md_read,
    output logic                     o_md_busy,
    output logic [15:0]              o_md_rdata,
    input  wire logic                i_mdc_tick,
    input  wire logic                i_mdi,
    output logic                     o_mdo,
    output logic                     o_mdio_en
);
    // -----------------------------------------------------------------
    // Link clock and pin synchronisation
    // -----------------------------------------------------------------
    logic [1:0]  clk_lvl;
    logic [1:0]  clk_rise;
    logic        txclk_prev_reg;
    logic        rxclk_prev_reg;
    logic        tx_edge;
    logic        rx_fall;
    logic [25:0] rxp_sync;
    logic [25:0] rxp_unused;
    logic        mdi_sync;
    logic        mdi_unused;

    gpdp_sync #(.W(2)) u_clk_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async ({i_rx_mac_clk, i_tx_mac_clk}),
        .o_sync  (clk_lvl),
        .o_rise  (clk_rise)
    );

    // The single-bus receive pins come from the receive link clock domain too,
    // so they share the classic pins' synchroniser and keep the same latency
    // as the sampled receive clock edges.
    gpdp_sync #(.W(26)) u_rx_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async ({i_rxdv_pos, i_rxdv_neg, i_rxer_pos, i_rxer_neg, i_rxd_pos, i_rxd_neg, i_rxdv, i_rxer, i_rxd}),
        .o_sync  (rxp_sync),
        .o_rise  (rxp_unused)
    );

    gpdp_sync #(.W(1)) u_mdi_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_mdi),
        .o_sync  (mdi_sync),
        .o_rise  (mdi_unused)
    );

    // The transmit clock is sampled, so at 125 MHz the sampled edges alias;
    // 1G operation is only meaningful with a link clock of at most a quarter of i_clk.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            txclk_prev_reg <= 1'h0;
            rxclk_prev_reg <= 1'h0;
        end else begin
            txclk_prev_reg <= clk_lvl[0];
            rxclk_prev_reg <= clk_lvl[1];
        end
    end

    assign tx_edge = clk_lvl[0] && !txclk_prev_reg;                             // [RULE9]
    assign rx_fall = !clk_lvl[1] && rxclk_prev_reg;

    // -----------------------------------------------------------------
    // Transmit path
    // -----------------------------------------------------------------
    logic gig_opt;
    assign gig_opt    = (i_option != gpdp_pkg::GPDP_CLASSIC);
    assign o_tx_ready = tx_edge;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_txd_pos <= 8'h00;
            o_txd_neg <= 4'h0;
            o_txd     <= 8'h00;
            o_txen    <= 1'h0;
            o_txer    <= 1'h0;
        end else if (tx_edge) begin
            o_txen <= i_tx_valid;                                               // [RULE11]
            o_txer <= i_tx_valid && i_tx_code_err;                              // [RULE12]
            if (gig_opt) begin
                o_txd     <= i_tx_valid ? i_tx_byte : 8'h00;                    // [RULE10]
                o_txd_pos <= 8'h00;
                o_txd_neg <= 4'h0;
            end else if (i_speed == gpdp_pkg::GPDP_SPEED_1G) begin
                o_txd     <= 8'h00;
                o_txd_pos <= i_tx_byte;                                         // [RULE3]
                o_txd_neg <= i_tx_byte[`GPDP_LO_MSB:`GPDP_LO_LSB];              // [RULE6]
            end else begin
                o_txd     <= 8'h00;
                o_txd_pos <= {4'h0, i_tx_byte[`GPDP_LO_MSB:`GPDP_LO_LSB]};      // [RULE4] [RULE7]
                o_txd_neg <= i_tx_byte[`GPDP_HI_MSB:`GPDP_HI_LSB];              // [RULE8]
            end
        end
    end

    // -----------------------------------------------------------------
    // Receive path
    // -----------------------------------------------------------------
    gpdp_rx_if rx_bus ();

    gpdp_rx_capture u_rx (
        .i_clk          (i_clk),
        .i_rst          (i_rst),
        .i_option       (i_option),
        .i_mac_clk_rise (clk_rise[1]),
        .i_mac_clk_fall (rx_fall),
        .i_dv_pos       (rxp_sync[25]),
        .i_dv_neg       (rxp_sync[24]),
        .i_er_pos       (rxp_sync[23]),
        .i_er_neg       (rxp_sync[22]),
        .i_d_pos        (rxp_sync[21:14]),
        .i_d_neg        (rxp_sync[13:10]),
        .i_dv           (rxp_sync[9]),
        .i_er           (rxp_sync[8]),
        .i_d            (rxp_sync[7:0]),
        .rx             (rx_bus.src)
    );

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rx_valid <= 1'h0;
            o_rx_err   <= 1'h0;
            o_rx_byte  <= 8'h00;
        end else begin
            o_rx_valid <= rx_bus.strobe && rx_bus.dv;
            o_rx_err   <= rx_bus.strobe && rx_bus.er;
            if (rx_bus.strobe && rx_bus.dv) begin
                o_rx_byte <= rx_bus.data;                                       // [RULE17]
            end
        end
    end

    // -----------------------------------------------------------------
    // Management data shifter
    // -----------------------------------------------------------------
    gpdp_pkg::gpdp_md_state_t md_state_reg;
    logic [15:0] md_shift_reg;
    logic [4:0]  md_cnt_reg;
    logic        md_read_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            md_state_reg <= gpdp_pkg::GPDP_MD_IDLE;
            md_shift_reg <= 16'h0000;
            md_cnt_reg   <= 5'h00;
            md_read_reg  <= 1'h0;
            o_md_rdata   <= 16'h0000;
        end else begin
            case (md_state_reg)
                gpdp_pkg::GPDP_MD_IDLE: begin
                    if (i_md_start) begin
                        md_shift_reg <= i_md_word;
                        md_read_reg  <= i_md_read;
                        md_cnt_reg   <= 5'h00;
                        md_state_reg <= gpdp_pkg::GPDP_MD_DRIVE;
                    end
                end
                gpdp_pkg::GPDP_MD_DRIVE: begin
                    if (i_mdc_tick) begin
                        md_shift_reg <= {md_shift_reg[14:0], 1'h0};
                        md_cnt_reg   <= md_cnt_reg + 5'h01;
                        if (md_cnt_reg == 5'h0F) begin
                            md_cnt_reg   <= 5'h00;
                            md_state_reg <= md_read_reg ? gpdp_pkg::GPDP_MD_LISTEN
                                                        : gpdp_pkg::GPDP_MD_IDLE;
                        end
                    end
                end
                gpdp_pkg::GPDP_MD_LISTEN: begin
                    if (i_mdc_tick) begin
                        md_shift_reg <= {md_shift_reg[14:0], mdi_sync};         // [RULE19]
                        md_cnt_reg   <= md_cnt_reg + 5'h01;
                        if (md_cnt_reg == 5'h0F) begin
                            o_md_rdata   <= {md_shift_reg[14:0], mdi_sync};
                            md_state_reg <= gpdp_pkg::GPDP_MD_IDLE;
                        end
                    end
                end
                default: begin
                    md_state_reg <= gpdp_pkg::GPDP_MD_IDLE;
                end
            endcase
        end
    end

    assign o_md_busy = (md_state_reg != gpdp_pkg::GPDP_MD_IDLE);
    assign o_mdo     = (md_state_reg == gpdp_pkg::GPDP_MD_DRIVE) && md_shift_reg[15];  // [RULE19]
    assign o_mdio_en = (md_state_reg == gpdp_pkg::GPDP_MD_DRIVE);                      // [RULE1]
endmodule
